// ===== rtl/clock_prescaler_sleep_control.v
// System clock prescaler with change protection and sleep entry and wake sequencing.
//
// Contract
// R1: Change enable sets only on a write of one with all other bits zero.
// R2: Change enable clears four cycles after setting or when the select is written.
// R3: Rewriting change enable inside its window neither restarts nor clears it.
// R4: Four-bit select in bits 3..0 sets the division ratio, changeable at run time.
// R5: Codes 0000 to 1000 divide by 1 to 256; 1001 to 1111 are reserved.
// R6: At reset select loads 0000, or 0011 when the divide-by-eight fuse is programmed.
// R7: Any select value written in the proper sequence is accepted regardless of fuse.
// R8: One division applies to core, flash and synchronous peripheral clock enables.
// R9: Software picks a division large enough for the source frequency.
// R10: Sleep happens only when the sleep instruction runs with sleep enable at one.
// R11: Mode select in bits 3..1: idle, noise reduction, power-down, power-save, standby.
// R12: An enabled interrupt during sleep wakes the device.
// R13: After interrupt wake the core stays halted four cycles beyond start-up time.
// R14: Register file and SRAM are kept across sleep entry and wake.
// R15: Reset during sleep wakes the device and execution starts at the reset vector.
// R16: Bits 7..4 of the sleep control register read as zero.
// R17: Idle stops only core and flash clocks; the rest keep running.
// R18: Idle wakes on external and internal interrupts.
// R19: Entering idle with the converter enabled starts a conversion.
// R20: Software sets sleep enable just before sleeping and clears it after wake.
// R21: Standby is advised only with a crystal or resonator source.
// R22: Software sets change enable alone, then writes select within four cycles.
// R23: Prescale change is glitch-free with no faster intermediate frequency.
// R24: Power-down halts all generated clocks.
// R25: A sleep instruction with a reserved mode code does not halt.
// R26: A reserved select code leaves the divider at its last valid factor.
`include "clock_prescaler_sleep_control_defines.vh"
`default_nettype none
module clock_prescaler_sleep_control (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire divide_by_eight_fuse_i,
	input wire [`ADDR_W-1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	input wire sleep_instr_i,
	input wire irq_pending_i,
	input wire adc_enabled_i,
	output reg core_clk_en_o,
	output reg flash_clk_en_o,
	output reg io_clk_en_o,
	output reg adc_clk_en_o,
	output reg async_clk_en_o,
	output reg osc_en_o,
	output reg sleeping_o,
	output reg core_halt_o,
	output reg wake_irq_o,
	output reg adc_start_o
);
	localparam ST_RUN = 2'h0;
	localparam ST_SLEEP = 2'h1;
	localparam ST_STARTUP = 2'h2;
	localparam ST_HALT = 2'h3;

	reg [3:0] prescale_select_q;
	reg [3:0] div_code_q;
	reg [3:0] pend_code_q;
	reg pend_q;
	reg prescale_change_enable_q;
	reg [2:0] pce_cnt_q;
	reg [2:0] sleep_mode_select_q;
	reg sleep_enable_q;
	reg [1:0] state_q;
	reg [2:0] mode_q;
	reg [3:0] wait_q;
	reg [7:0] div_cnt_q;
	reg fuse_seen_q;
	reg fuse_meta_q;
	reg fuse_sync_q;
	reg sys_tick;
	wire wr_ps = reg_wr_i && (reg_addr_i == `OFF_PRESCALE_CTRL);
	wire wr_sm = reg_wr_i && (reg_addr_i == `OFF_SLEEP_CTRL);
	wire pce_only = (reg_wdata_i == 8'h80);

	function [7:0] div_mask;
		input [3:0] code;
		begin
			div_mask = 8'hff >> (4'h8 - code);
			if (code == 4'h0) begin
				div_mask = 8'h00;
			end
		end
	endfunction

	function mode_valid;
		input [2:0] m;
		begin
			mode_valid = (m == `MODE_IDLE) || (m == `MODE_ADC_NR) ||
				(m == `MODE_PWR_DOWN) || (m == `MODE_PWR_SAVE) || (m == `MODE_STANDBY);
		end
	endfunction

	// The fuse level comes from outside the clock domain, so it passes two flip-flops.
	// These flops have no reset, so the fuse value is already settled when reset is released.
	always @(posedge core_clk_i) begin
		fuse_meta_q <= divide_by_eight_fuse_i;
		fuse_sync_q <= fuse_meta_q;
	end

	// Prescale register and its timed change window.
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prescale_select_q <= `PS_RESET_FUSE_OFF;
			prescale_change_enable_q <= 1'b0;
			pce_cnt_q <= 3'h0;
			fuse_seen_q <= 1'b0;
			pend_q <= 1'b0;
			pend_code_q <= 4'h0;
		end else begin
			if (!fuse_seen_q) begin
				fuse_seen_q <= 1'b1;
				if (fuse_sync_q) begin
					prescale_select_q <= `PS_RESET_FUSE_ON; // R6
					pend_q <= 1'b1;
					pend_code_q <= `PS_RESET_FUSE_ON;
				end
			end
			if (prescale_change_enable_q) begin
				pce_cnt_q <= pce_cnt_q - 3'h1; // R3
				if (pce_cnt_q == 3'h1) begin
					prescale_change_enable_q <= 1'b0; // R2
				end
			end
			if (wr_ps && pce_only && !prescale_change_enable_q) begin
				prescale_change_enable_q <= 1'b1; // R1
				pce_cnt_q <= `PCE_WINDOW_CYC;
			end else if (wr_ps && prescale_change_enable_q && !reg_wdata_i[`PCE_BIT]) begin
				prescale_change_enable_q <= 1'b0; // R2
				prescale_select_q <= reg_wdata_i[`PS_HI:`PS_LO]; // R4 R7
				if (reg_wdata_i[`PS_HI:`PS_LO] <= `PS_MAX_VALID) begin
					pend_q <= 1'b1; // R26
					pend_code_q <= reg_wdata_i[`PS_HI:`PS_LO];
				end
			end
			if (pend_q && sys_tick) begin
				pend_q <= 1'b0;
			end
		end
	end

	// The new ratio is taken only on an old-rate tick, so no short pulse appears.
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_code_q <= 4'h0;
			div_cnt_q <= 8'h00;
		end else if (sys_tick) begin
			div_cnt_q <= 8'h00;
			if (pend_q) begin
				div_code_q <= pend_code_q; // R23
			end
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01;
		end
	end

	always @* begin
		sys_tick = ((div_cnt_q & div_mask(div_code_q)) == div_mask(div_code_q)); // R5 R8
	end

	// Sleep control register.
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sleep_mode_select_q <= 3'h0;
			sleep_enable_q <= 1'b0;
		end else if (wr_sm) begin
			sleep_mode_select_q <= reg_wdata_i[`SM_HI:`SM_LO]; // R11
			sleep_enable_q <= reg_wdata_i[`SE_BIT];
		end
	end

	// Sleep sequencer; memories are outside and simply keep their contents while clocks stop.
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= ST_RUN; // R15
			mode_q <= `MODE_IDLE;
			wait_q <= 4'h0;
			adc_start_o <= 1'b0;
			wake_irq_o <= 1'b0;
		end else begin
			adc_start_o <= 1'b0;
			wake_irq_o <= 1'b0;
			case (state_q)
				ST_RUN: begin
					if (sleep_instr_i && sleep_enable_q && mode_valid(sleep_mode_select_q)) begin
						state_q <= ST_SLEEP; // R10 R25 R14
						mode_q <= sleep_mode_select_q;
						adc_start_o <= adc_enabled_i && (sleep_mode_select_q == `MODE_IDLE ||
							sleep_mode_select_q == `MODE_ADC_NR); // R19
					end
				end
				ST_SLEEP: begin
					if (irq_pending_i) begin
						state_q <= ST_STARTUP; // R12 R18
						wait_q <= (mode_q == `MODE_IDLE || mode_q == `MODE_ADC_NR) ?
							4'h0 : `STARTUP_CYC;
					end
				end
				ST_STARTUP: begin
					if (wait_q == 4'h0) begin
						state_q <= ST_HALT;
						wait_q <= {1'b0, `WAKE_HALT_CYC};
					end else begin
						wait_q <= wait_q - 4'h1;
					end
				end
				ST_HALT: begin
					if (wait_q == 4'h1) begin
						state_q <= ST_RUN; // R13
						wake_irq_o <= 1'b1;
					end
					wait_q <= wait_q - 4'h1;
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// Clock enables; stopped domains keep their state frozen.
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			core_clk_en_o <= 1'b0;
			flash_clk_en_o <= 1'b0;
			io_clk_en_o <= 1'b0;
			adc_clk_en_o <= 1'b0;
			async_clk_en_o <= 1'b0;
			osc_en_o <= 1'b1;
			sleeping_o <= 1'b0;
			core_halt_o <= 1'b0;
		end else begin
			sleeping_o <= (state_q == ST_SLEEP);
			core_halt_o <= (state_q != ST_RUN);
			core_clk_en_o <= sys_tick && (state_q == ST_RUN); // R8
			flash_clk_en_o <= sys_tick && (state_q == ST_RUN);
			if (state_q == ST_RUN) begin
				io_clk_en_o <= sys_tick;
				adc_clk_en_o <= sys_tick;
				async_clk_en_o <= sys_tick;
				osc_en_o <= 1'b1;
			end else begin
				case (mode_q)
					`MODE_IDLE: begin
						io_clk_en_o <= sys_tick; // R17
						adc_clk_en_o <= sys_tick;
						async_clk_en_o <= sys_tick;
						osc_en_o <= 1'b1;
					end
					`MODE_ADC_NR: begin
						io_clk_en_o <= 1'b0;
						adc_clk_en_o <= sys_tick;
						async_clk_en_o <= sys_tick;
						osc_en_o <= 1'b1;
					end
					`MODE_PWR_SAVE: begin
						io_clk_en_o <= 1'b0;
						adc_clk_en_o <= 1'b0;
						async_clk_en_o <= sys_tick;
						osc_en_o <= 1'b0;
					end
					`MODE_STANDBY: begin
						io_clk_en_o <= 1'b0;
						adc_clk_en_o <= 1'b0;
						async_clk_en_o <= 1'b0;
						osc_en_o <= 1'b1;
					end
					default: begin
						io_clk_en_o <= 1'b0; // R24
						adc_clk_en_o <= 1'b0;
						async_clk_en_o <= 1'b0;
						osc_en_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// Read port, data valid in the cycle after the strobe.
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`OFF_PRESCALE_CTRL: reg_rdata_o <= {prescale_change_enable_q, 3'h0, prescale_select_q};
				`OFF_SLEEP_CTRL: reg_rdata_o <= {4'h0, sleep_mode_select_q, sleep_enable_q}; // R16
				`OFF_STATUS: reg_rdata_o <= {2'h0, state_q, div_code_q};
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/clock_prescaler_sleep_control_defines.vh
// Register offsets, field positions, reset values and timing counts of the clock and sleep block.
`ifndef CLOCK_PRESCALER_SLEEP_CONTROL_DEFINES_VH
`define CLOCK_PRESCALER_SLEEP_CONTROL_DEFINES_VH
`define ADDR_W 4
`define OFF_PRESCALE_CTRL 4'h0
`define OFF_SLEEP_CTRL 4'h1
`define OFF_STATUS 4'h2
`define PCE_BIT 7
`define PS_HI 3
`define PS_LO 0
`define SM_HI 3
`define SM_LO 1
`define SE_BIT 0
`define PS_RESET_FUSE_OFF 4'h0
`define PS_RESET_FUSE_ON 4'h3
`define PS_MAX_VALID 4'h8
`define PCE_WINDOW_CYC 3'h4
`define WAKE_HALT_CYC 3'h4
`define STARTUP_CYC 4'h6
`define MODE_IDLE 3'h0
`define MODE_ADC_NR 3'h1
`define MODE_PWR_DOWN 3'h2
`define MODE_PWR_SAVE 3'h3
`define MODE_STANDBY 3'h6
`endif

// ===== testbench/clock_prescaler_sleep_control_assertions.sv
// Port-level checks for the clock prescaler and sleep control block.
`default_nettype none
module clock_prescaler_sleep_control_checker (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic sleep_instr_i,
	input wire logic irq_pending_i,
	input wire logic core_clk_en_o,
	input wire logic flash_clk_en_o,
	input wire logic io_clk_en_o,
	input wire logic osc_en_o,
	input wire logic sleeping_o,
	input wire logic core_halt_o,
	input wire logic wake_irq_o,
	input wire logic adc_start_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	pad_zero_a: assert property (
		$past(reg_rd_i) && $past(reg_addr_i) == 4'h1 |-> reg_rdata_o[7:4] == 4'h0)
		else $error("pad bits set");
	sleep_cause_a: assert property ($rose(sleeping_o) |-> $past(sleep_instr_i, 2))
		else $error("sleep without instruction");
	irq_wake_a: assert property (sleeping_o && irq_pending_i |-> ##[1:20] wake_irq_o)
		else $error("no wake");
	halt_before_a: assert property (
		wake_irq_o |-> $past(core_halt_o, 4) && $past(core_halt_o))
		else $error("halt too short");
	halt_end_a: assert property (wake_irq_o |=> !core_halt_o && !wake_irq_o)
		else $error("halt not released");
	down_clocks_a: assert property (!osc_en_o |-> !core_clk_en_o && !io_clk_en_o)
		else $error("clock with oscillator off");
	same_div_a: assert property (flash_clk_en_o == core_clk_en_o)
		else $error("flash and core differ");
	adc_entry_a: assert property (adc_start_o |-> ##[0:2] sleeping_o)
		else $error("conversion start outside entry");
	sleep_core_a: assert property (sleeping_o |-> !core_clk_en_o && !flash_clk_en_o)
		else $error("core clock while sleeping");
endmodule
bind clock_prescaler_sleep_control clock_prescaler_sleep_control_checker chk (
	.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sleep_instr_i(sleep_instr_i),
	.irq_pending_i(irq_pending_i), .core_clk_en_o(core_clk_en_o),
	.flash_clk_en_o(flash_clk_en_o), .io_clk_en_o(io_clk_en_o), .osc_en_o(osc_en_o),
	.sleeping_o(sleeping_o), .core_halt_o(core_halt_o), .wake_irq_o(wake_irq_o),
	.adc_start_o(adc_start_o));
`default_nettype wire

// ===== testbench/core_model.sv
// Behavioural processor core: issues the sleep instruction and raises a wake interrupt.
`default_nettype none
module core_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic wake_i,
	input wire logic [5:0] dly_i,
	output logic sleep_o,
	output logic irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sleep_o <= 1'b0;
			irq_o <= 1'b0;
			cnt <= 0;
		end else begin
			sleep_o <= go_i;
			cnt <= go_i ? 1 : (cnt > 0 ? cnt + 1 : 0);
			if (cnt == dly_i)
				irq_o <= 1'b1;
			// The request stays pending until the wake is seen, or until the count passes 60.
			if (wake_i || cnt > 60) begin
				irq_o <= 1'b0;
				cnt <= 0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/test_clock_prescaler_sleep_control.sv
// Self-checking bench for the clock prescaler and sleep control block.
`default_nettype none
module test_clock_prescaler_sleep_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, adc = 1'b1;
	logic [3:0] a = 4'h0;
	logic [7:0] d = 8'h00, q;
	logic [5:0] dy = 6'h08;
	logic sl, irq, ce, slp, hlt, wk;
	int failures = 0, compares = 0, n;
	initial forever #2.5 clk = ~clk;
	clock_prescaler_sleep_control dut (.core_clk_i(clk), .sys_rst_i(rst),
		.divide_by_eight_fuse_i(1'b1), .reg_addr_i(a), .reg_wdata_i(d), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(q), .sleep_instr_i(sl), .irq_pending_i(irq),
		.adc_enabled_i(adc), .core_clk_en_o(ce), .flash_clk_en_o(), .io_clk_en_o(),
		.adc_clk_en_o(), .async_clk_en_o(), .osc_en_o(), .sleeping_o(slp),
		.core_halt_o(hlt), .wake_irq_o(wk), .adc_start_o());
	core_model core (.clk_i(clk), .rst_i(rst), .go_i(go), .wake_i(wk), .dly_i(dy),
		.sleep_o(sl), .irq_o(irq));
	task summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [15:0] s, e, input string nm);
		compares++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wrt(input logic [3:0] ad, input logic [7:0] v);
		@(posedge clk) begin a <= ad; d <= v; wr <= 1'b1; end
		@(posedge clk) wr <= 1'b0;
	endtask
	task rdc(input logic [3:0] ad, input logic [7:0] e);
		@(posedge clk) begin a <= ad; rd <= 1'b1; end
		@(posedge clk) rd <= 1'b0;
		#1 chk({8'h00, q}, {8'h00, e}, "rdata");
	endtask
	task setps(input logic [7:0] v);
		wrt(4'h0, 8'h80);
		wrt(4'h0, v);
	endtask
	// The first intervals after a change may be transitional, so only the third counts.
	task period(output int p);
		repeat (3) begin
			p = 0;
			do begin @(posedge clk); #1 p++; end while (ce !== 1'b1 && p < 600);
		end
	endtask
	task nap(input logic [3:0] v, input logic x);
		wrt(4'h1, {4'h0, v});
		@(posedge clk) go <= 1'b1;
		@(posedge clk) go <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({15'h0, slp}, {15'h0, x}, "sleeping");
		n = 0;
		do begin @(posedge clk); #1 n++; end while (wk !== 1'b1 && n < 60);
		chk({15'h0, wk}, {15'h0, x}, "wake");
		repeat (10) @(posedge clk);
	endtask
	initial begin
		#200us;
		failures++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rdc(4'h0, 8'h03);
		rdc(4'hf, 8'h00);
		period(n);
		chk(n[15:0], 16'h0008, "period");
		for (int c = 0; c <= 8; c++) begin
			setps(8'(c));
			rdc(4'h0, 8'(c));
			period(n);
			chk(n[15:0], 16'(1 << c), "period");
		end
		wrt(4'h0, 8'h81);
		wrt(4'h0, 8'h02);
		rdc(4'h0, 8'h08);
		wrt(4'h0, 8'h80);
		wrt(4'h0, 8'h80);
		@(posedge clk);
		wrt(4'h0, 8'h02);
		rdc(4'h0, 8'h08);
		for (int k = 1; k <= 2; k++) begin
			wrt(4'h0, 8'h80);
			repeat (2 * k - 1) @(posedge clk);
			wrt(4'h0, 8'(k));
			rdc(4'h0, 8'h01);
		end
		setps(8'h09);
		rdc(4'h0, 8'h09);
		period(n);
		chk(n[15:0], 16'h0002, "period");
		$display("test prescale done");
		for (int m = 0; m < 8; m++) begin
			dy <= m[0] ? 6'h14 : 6'h08;
			nap({m[2:0], 1'b1}, m < 4 || m == 6);
		end
		nap(4'h0, 1'b0);
		wrt(4'h1, 8'hff);
		rdc(4'h1, 8'h0f);
		wrt(4'h1, 8'h05);
		@(posedge clk) go <= 1'b1;
		@(posedge clk) go <= 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk({15'h0, slp}, 16'h0000, "sleeping");
		chk({15'h0, hlt}, 16'h0000, "halt");
		rdc(4'h1, 8'h00);
		$display("test sleep done");
		summarize();
	end
endmodule
`default_nettype wire
